// File: src/dwac_walk.sv
/*
 Descriptor walk and access check: translates a virtual word address by walking
 descriptor tables in memory and checks the reference against ring brackets.
 Assumes a memory port on MCLK with a ready handshake, and an APB master on MCLK.
*/
// The register addresses and the APB interface to the registers were decided locally.
// Functional notes
// - Direct root, direct first descriptor: low 11 bits offset a 2048-word segment.
// - Direct root, indirect first: next four bits as page, two zero bits appended.
// - Direct root, direct page descriptor: low 7 bits offset a 128-word page.
// - Direct root, indirect second descriptor: abort and trap.
// - Indirect root: top 4 address bits index the first table.
// - Indirect root, direct first descriptor: trap.
// - Indirect root, indirect first: next five bits index; direct gives 11-bit offset.
// - Indirect root, indirect second: next 4 bits index page table; 7-bit offset.
// - Indirect root, indirect third descriptor: trap.
// - Every reference is classed read, write or execute and checked so; the code checks only mapped references while enable_r is set.
// - Requested mode is compared with effective mode; violation traps.
// - Access controls may come from any level, chosen by a per-descriptor flag.
// - Effective access compares effective ring with brackets, then permission bits.
// - Simple references use the current ring as effective ring.
// - Address constant fetches are translated and checked as data reads.
// - Effective ring resets to current ring at each instruction fetch.
// - Each descriptor raises effective ring to its write bracket top if higher; execute references keep the current ring.
// - Each descriptor is four memory words.
// - Two-bit forced trap field; only 10 continues, others trap.
// - First descriptor with access flag on governs the reference.
// - No descriptor with access flag on raises a trap.
// - Ring bracket fields hold at least values 0 to 3.
// - A 20-bit word address is mapped; byte select passes unchanged.
// - Top bus address bit marks mapped; zero passes without mediation.
// - Root pointer type field selects direct or indirect walk.
// - Write needs permit and ring within write bracket; read, execute likewise.
`timescale 1ns/10ps
`include "dwac_defines.svh"
module dwac_walk
  import dwac_pkg::*;
#(
  parameter int RING_W = 4
) (
  input wire logic MCLK,
  input wire logic SRST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic REQ_VALID,
  input wire dwac_req_t REQ,
  output logic REQ_READY,
  output logic DONE,
  output logic [23:0] PHYS_ADDR,
  output logic PHYS_BYTE,
  output logic TRAP,
  output logic [2:0] TRAP_CAUSE,
  output logic MEM_RD,
  output logic [19:0] MEM_ADDR,
  input wire logic [15:0] MEM_RDATA,
  input wire logic MEM_READY
);
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_FETCH,
    ST_EVAL,
    ST_CHECK,
    ST_DONE
  } dwac_st_t;

  dwac_st_t st_r, st_nxt;
  logic [31:0] root_r;
  logic enable_r;
  logic [23:0] va_r;
  logic byte_r;
  dwac_mode_t mode_r;
  logic [RING_W-1:0] reff_r;
  logic [1:0] lvl_r;
  logic [1:0] wcnt_r;
  logic [15:0] word_r [0:3];
  logic [19:0] tbase_r;
  logic have_acc_r;
  dwac_desc_t gov_r;
  logic [19:0] dbase_r;
  logic [10:0] off_r;
  logic [23:0] phys_r;
  logic done_r;
  logic trap_r;
  logic [2:0] cause_r;
  logic [2:0] last_cause_r;
  logic [15:0] trap_cnt_r;

  wire root_ind = (root_r[`DWAC_ROOT_TYPE_LSB +: 3] == `DWAC_TYPE_IND);
  wire [19:0] root_base = {root_r[15:0], 4'h0};
  wire [19:0] vword = va_r[19:0];

  // Descriptor assembled from the first three of four fetched words
  dwac_desc_t cur_d;
  assign cur_d.typ = word_r[0][`DWAC_W0_TYPE_LSB +: 3];
  assign cur_d.dt = word_r[0][`DWAC_W0_DT_LSB +: 2];
  assign cur_d.acc = word_r[0][`DWAC_W0_ACC_BIT];
  assign cur_d.perm_r = word_r[0][`DWAC_W0_R_BIT];
  assign cur_d.perm_w = word_r[0][`DWAC_W0_W_BIT];
  assign cur_d.perm_e = word_r[0][`DWAC_W0_E_BIT];
  assign cur_d.wb_top = word_r[1][`DWAC_W1_WB_LSB +: 4];
  assign cur_d.xb_top = word_r[1][`DWAC_W1_XB_LSB +: 4];
  assign cur_d.cb_top = word_r[1][`DWAC_W1_CB_LSB +: 4];
  assign cur_d.base = word_r[2];

  wire cur_dir = (cur_d.typ == `DWAC_TYPE_DIR) || (cur_d.typ == `DWAC_TYPE_PAGE);
  wire cur_ind = (cur_d.typ == `DWAC_TYPE_IND);
  wire dt_trap = (cur_d.dt != `DWAC_DT_PASS);
  wire [19:0] ind_base = {cur_d.base, 4'h0};
  wire [19:0] dir_base = {cur_d.base[12:0], 7'h00};

  // Table index for the next level, by root kind and level
  logic [10:0] next_idx;
  logic struct_trap;
  logic final_seg;
  logic final_page;
  always_comb begin
    next_idx = 11'h000;
    struct_trap = 1'b0;
    final_seg = 1'b0;
    final_page = 1'b0;
    if (!root_ind) begin
      if (lvl_r == 2'd0) begin
        if (cur_dir) begin
          final_seg = 1'b1;
        end else if (cur_ind) begin
          next_idx = {5'h00, vword[10:7], 2'b00};
        end else begin
          struct_trap = 1'b1;
        end
      end else begin
        if (cur_dir) begin
          final_page = 1'b1;
        end else begin
          struct_trap = 1'b1;
        end
      end
    end else begin
      if (lvl_r == 2'd0) begin
        if (cur_ind) begin
          next_idx = {6'h00, vword[15:11]};
        end else begin
          struct_trap = 1'b1;
        end
      end else if (lvl_r == 2'd1) begin
        if (cur_dir) begin
          final_seg = 1'b1;
        end else if (cur_ind) begin
          next_idx = {7'h00, vword[10:7]};
        end else begin
          struct_trap = 1'b1;
        end
      end else begin
        if (cur_dir) begin
          final_page = 1'b1;
        end else begin
          struct_trap = 1'b1;
        end
      end
    end
  end

  // First-level index: whole segment number for direct root, top 4 bits otherwise
  wire [10:0] first_idx = root_ind ? {7'h00, REQ.addr[19:16]}
                                   : {2'h0, REQ.addr[19:11]};
  wire [19:0] fetch_addr = tbase_r + {7'h00, off_r, 2'b00} + {18'h0, wcnt_r};

  // Effective ring update and governing descriptor selection
  wire [RING_W-1:0] cur_wb = RING_W'(cur_d.wb_top);
  wire [RING_W-1:0] reff_upd = (cur_wb > reff_r) ? cur_wb : reff_r;
  wire take_acc = cur_d.acc && !have_acc_r;

  // Access check against governing descriptor
  wire [RING_W-1:0] g_wb = RING_W'(gov_r.wb_top);
  wire [RING_W-1:0] g_xb = RING_W'(gov_r.xb_top);
  wire ok_w = gov_r.perm_w && (reff_r <= g_wb);
  wire ok_r = gov_r.perm_r && (reff_r <= g_xb);
  wire ok_x = gov_r.perm_e && (g_wb <= reff_r) && (reff_r <= g_xb);
  logic granted;
  always_comb begin
    case (mode_r)
      DWAC_WRITE: granted = ok_w;
      DWAC_EXEC: granted = ok_x;
      default: granted = ok_r;
    endcase
  end

  wire acc_req = REQ_VALID && (st_r == ST_IDLE);
  wire bypass = !REQ.addr[23] || !enable_r;
  wire last_word = (wcnt_r == 2'd3);

  // Descriptor word capture, one register per word
  for (genvar gi = 0; gi < 4; gi++) begin : g_word
    always_ff @(posedge MCLK) begin
      if (SRST) begin
        word_r[gi] <= 16'h0000;
      end else if ((st_r == ST_FETCH) && MEM_READY && (wcnt_r == 2'(gi))) begin
        word_r[gi] <= MEM_RDATA;
      end
    end
  end

  always_comb begin
    st_nxt = st_r;
    case (st_r)
      ST_IDLE: begin
        if (acc_req && !bypass) begin
          st_nxt = ST_FETCH;
        end else if (acc_req) begin
          st_nxt = ST_DONE;
        end
      end
      ST_FETCH: begin
        if (MEM_READY && last_word) begin
          st_nxt = ST_EVAL;
        end
      end
      ST_EVAL: begin
        if (dt_trap || struct_trap || final_seg || final_page) begin
          st_nxt = ST_CHECK;
        end else begin
          st_nxt = ST_FETCH;
        end
      end
      ST_CHECK: st_nxt = ST_DONE;
      ST_DONE: st_nxt = ST_IDLE;
      default: st_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge MCLK) begin
    if (SRST) begin
      st_r <= ST_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Walk datapath
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      va_r <= 24'h000000;
      byte_r <= 1'b0;
      mode_r <= DWAC_READ;
      reff_r <= '0;
      lvl_r <= 2'd0;
      wcnt_r <= 2'd0;
      tbase_r <= 20'h00000;
      off_r <= 11'h000;
      have_acc_r <= 1'b0;
      gov_r <= '0;
      dbase_r <= 20'h00000;
      cause_r <= `DWAC_CAUSE_NONE;
    end else begin
      case (st_r)
        ST_IDLE: begin
          if (acc_req) begin
            va_r <= REQ.addr;
            byte_r <= REQ.byte_sel;
            mode_r <= REQ.mode;
            if (REQ.new_instr || REQ.mode == DWAC_EXEC) begin
              reff_r <= RING_W'(REQ.cur_ring);
            end
            lvl_r <= 2'd0;
            wcnt_r <= 2'd0;
            tbase_r <= root_base;
            off_r <= first_idx;
            have_acc_r <= 1'b0;
            cause_r <= `DWAC_CAUSE_NONE;
          end
        end
        ST_FETCH: begin
          if (MEM_READY) begin
            wcnt_r <= wcnt_r + 2'd1;
          end
        end
        ST_EVAL: begin
          if (mode_r != DWAC_EXEC) begin
            reff_r <= reff_upd;
          end
          if (take_acc) begin
            gov_r <= cur_d;
            have_acc_r <= 1'b1;
          end
          if (dt_trap) begin
            cause_r <= `DWAC_CAUSE_DT;
          end else if (struct_trap) begin
            cause_r <= `DWAC_CAUSE_STRUCT;
          end else if (final_seg) begin
            dbase_r <= dir_base + {9'h000, vword[10:0]};
          end else if (final_page) begin
            dbase_r <= dir_base + {13'h0000, vword[6:0]};
          end else begin
            tbase_r <= ind_base;
            off_r <= next_idx;
            lvl_r <= lvl_r + 2'd1;
            wcnt_r <= 2'd0;
          end
        end
        ST_CHECK: begin
          if (cause_r == `DWAC_CAUSE_NONE) begin
            if (!have_acc_r) begin
              cause_r <= `DWAC_CAUSE_NOACC;
            end else if (!granted) begin
              cause_r <= `DWAC_CAUSE_VIOL;
            end
          end
        end
        default: ;
      endcase
    end
  end

  // Result outputs
  wire fin = (st_r == ST_DONE);
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      done_r <= 1'b0;
      trap_r <= 1'b0;
      phys_r <= 24'h000000;
      last_cause_r <= `DWAC_CAUSE_NONE;
      trap_cnt_r <= 16'h0000;
    end else begin
      done_r <= fin;
      trap_r <= fin && (cause_r != `DWAC_CAUSE_NONE);
      if (fin) begin
        phys_r <= va_r[23] && enable_r ? {4'h0, dbase_r} : va_r;
        last_cause_r <= cause_r;
        if (cause_r != `DWAC_CAUSE_NONE) begin
          trap_cnt_r <= trap_cnt_r + 16'h0001;
        end
      end
    end
  end

  assign REQ_READY = (st_r == ST_IDLE);
  assign DONE = done_r;
  assign TRAP = trap_r;
  assign TRAP_CAUSE = last_cause_r;
  assign PHYS_ADDR = phys_r;
  assign PHYS_BYTE = byte_r;
  assign MEM_RD = (st_r == ST_FETCH);
  assign MEM_ADDR = fetch_addr;

  // APB slave, zero wait states
  wire apb_wr = PSEL && PENABLE && PWRITE;
  wire hit_root = (PADDR == `DWAC_ROOT_OFS);
  wire hit_ctrl = (PADDR == `DWAC_CTRL_OFS);
  wire hit_stat = (PADDR == `DWAC_STAT_OFS);
  wire hit_addr = (PADDR == `DWAC_ADDR_OFS);
  wire hit_any = hit_root || hit_ctrl || hit_stat || hit_addr;
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      root_r <= `DWAC_ROOT_RESET;
      enable_r <= 1'b0;
    end else if (apb_wr && hit_root) begin
      root_r <= PWDATA;
    end else if (apb_wr && hit_ctrl) begin
      enable_r <= PWDATA[0];
    end
  end

  wire [31:0] stat_word = {trap_cnt_r, 8'h00, RING_W'(reff_r), 1'b0, last_cause_r};
  // Read word captured in the setup cycle
  logic [31:0] prdata_r;
  wire [31:0] rd_mux = hit_root ? root_r :
                       hit_ctrl ? {31'h0, enable_r} :
                       hit_stat ? stat_word :
                       hit_addr ? {8'h00, phys_r} : 32'h0;
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      prdata_r <= 32'h0000_0000;
    end else if (PSEL && !PENABLE) begin
      prdata_r <= rd_mux;
    end
  end
  assign PRDATA = prdata_r;
  assign PREADY = 1'b1;
  assign PSLVERR = PSEL && PENABLE && !hit_any;
endmodule : dwac_walk

// File: include/dwac_defines.svh
/*
 Descriptor walk access check: offsets, field positions, encodings, trap cause codes and descriptor size.
 Assumes inclusion by the design file and the test bench only.
*/
`ifndef DWAC_DEFINES_SVH
`define DWAC_DEFINES_SVH
// APB register byte offsets
`define DWAC_ROOT_OFS 12'h000
`define DWAC_CTRL_OFS 12'h004
`define DWAC_STAT_OFS 12'h008
`define DWAC_ADDR_OFS 12'h00c
// Descriptor type encodings
`define DWAC_TYPE_DIR 3'h4
`define DWAC_TYPE_IND 3'h1
`define DWAC_TYPE_PAGE 3'h2
// Directed trap value that lets the walk continue
`define DWAC_DT_PASS 2'h2
// Descriptor word 0 field positions
`define DWAC_W0_TYPE_LSB 0
`define DWAC_W0_DT_LSB 3
`define DWAC_W0_ACC_BIT 5
`define DWAC_W0_R_BIT 6
`define DWAC_W0_W_BIT 7
`define DWAC_W0_E_BIT 8
// Descriptor word 1 ring bracket positions
`define DWAC_W1_WB_LSB 0
`define DWAC_W1_XB_LSB 4
`define DWAC_W1_CB_LSB 8
// Root pointer field positions
`define DWAC_ROOT_TYPE_LSB 16
`define DWAC_ROOT_RESET 32'h0000_0000
// Trap cause codes
`define DWAC_CAUSE_NONE 3'h0
`define DWAC_CAUSE_STRUCT 3'h1
`define DWAC_CAUSE_DT 3'h2
`define DWAC_CAUSE_NOACC 3'h3
`define DWAC_CAUSE_VIOL 3'h4
// Number of words in one descriptor
`define DWAC_DESC_WORDS 3'h4
`endif

// File: include/dwac_pkg.sv
/*
 Types shared by the descriptor walk access check.
 Assumes dwac_defines.svh is on the include path.
*/
package dwac_pkg;
  typedef enum logic [1:0] {
    DWAC_READ,
    DWAC_WRITE,
    DWAC_EXEC
  } dwac_mode_t;

  typedef struct packed {
    logic [1:0] dt;
    logic acc;
    logic perm_r;
    logic perm_w;
    logic perm_e;
    logic [2:0] typ;
    logic [3:0] wb_top;
    logic [3:0] xb_top;
    logic [3:0] cb_top;
    logic [15:0] base;
  } dwac_desc_t;

  typedef struct packed {
    logic [23:0] addr;
    logic byte_sel;
    dwac_mode_t mode;
    logic new_instr;
    logic [3:0] cur_ring;
  } dwac_req_t;
endpackage : dwac_pkg

// File: sim/dwac_walk_asserts.sv
/* Checker on dwac_walk ports: request latency, bypass, descriptor fetch counts.
   Assumes MCLK clocks every port and SRST is synchronous. */
`timescale 1ns/10ps
module dwac_walk_asserts
  import dwac_pkg::*;
(
  input wire logic MCLK,
  input wire logic SRST,
  input wire logic REQ_VALID,
  input wire dwac_req_t REQ,
  input wire logic REQ_READY,
  input wire logic DONE,
  input wire logic [23:0] PHYS_ADDR,
  input wire logic PHYS_BYTE,
  input wire logic TRAP,
  input wire logic [2:0] TRAP_CAUSE,
  input wire logic MEM_RD,
  input wire logic MEM_READY
);
  logic take;
  logic byte_r;
  logic [5:0] words_r;
  assign take = REQ_VALID && REQ_READY;
  // Byte select of the request in flight and memory words fetched for it
  always_ff @(posedge MCLK) begin
    byte_r <= take ? REQ.byte_sel : byte_r;
    words_r <= (SRST || take) ? 6'h0 : words_r + 6'(MEM_RD && MEM_READY);
  end
  default clocking @(posedge MCLK); endclocking
  default disable iff (SRST);
  bypass_done_a: assert property (take && !REQ.addr[23] |-> ##2 DONE && !TRAP
    && PHYS_ADDR == $past(REQ.addr, 2)) else $error("bypass result wrong");
  bypass_quiet_a: assert property (take && !REQ.addr[23] |=> !MEM_RD [*2])
    else $error("fetch on bypass");
  byte_pass_a: assert property (DONE |-> PHYS_BYTE == byte_r)
    else $error("byte select changed");
  desc_words_a: assert property (DONE |-> words_r[1:0] == 2'h0)
    else $error("partial descriptor");
  walk_depth_a: assert property (DONE |-> words_r <= 6'd12)
    else $error("walk too deep");
  done_bound_a: assert property (take |-> ##[2:600] DONE) else $error("no done");
  done_pulse_a: assert property (DONE |=> !DONE) else $error("done too long");
  trap_cause_a: assert property (DONE |-> (TRAP ? TRAP_CAUSE inside {[3'h1:3'h4]}
    : TRAP_CAUSE == 3'h0)) else $error("cause mismatch");
  trap_done_a: assert property (TRAP |-> DONE) else $error("trap alone");
  cover property (DONE && TRAP);
  cover property (take && !REQ.addr[23]);
  cover property (MEM_RD && !MEM_READY);
endmodule : dwac_walk_asserts
bind dwac_walk dwac_walk_asserts i_dwac_walk_asserts (.MCLK(MCLK), .SRST(SRST),
  .REQ_VALID(REQ_VALID), .REQ(REQ), .REQ_READY(REQ_READY), .DONE(DONE),
  .PHYS_ADDR(PHYS_ADDR), .PHYS_BYTE(PHYS_BYTE), .TRAP(TRAP), .TRAP_CAUSE(TRAP_CAUSE),
  .MEM_RD(MEM_RD), .MEM_READY(MEM_READY));

// File: sim/dwac_mem_model.sv
/* Memory holding descriptor tables: word reads with random wait cycles.
   Assumes the bench fills mem before each request. */
`timescale 1ns/10ps
module dwac_mem_model (
  input wire logic MCLK,
  input wire logic SRST,
  input wire logic MEM_RD,
  input wire logic [19:0] MEM_ADDR,
  output logic [15:0] MEM_RDATA,
  output logic MEM_READY
);
  logic [15:0] mem [int];
  logic go_r = 1'b0;
  logic [15:0] junk_r = 16'h5a3c;
  function automatic logic [15:0] rd(input logic [19:0] a);
    return mem.exists(int'(a)) ? mem[int'(a)] : 16'h0;
  endfunction : rd
  // Random stalls; data off the handshake changes every cycle
  always @(posedge MCLK) begin
    go_r <= !SRST && ($urandom_range(0, 2) != 0);
    junk_r <= junk_r + 16'h3b1d;
  end
  assign MEM_READY = MEM_RD && go_r;
  assign MEM_RDATA = MEM_READY ? rd(MEM_ADDR) : junk_r;
endmodule : dwac_mem_model

// File: sim/dwac_walk_test.sv
/* Bench for dwac_walk: APB set-up, random and corner walks, result checks.
   Assumes the memory model answers the fetch port. */
`timescale 1ns/10ps
`include "dwac_defines.svh"
module dwac_walk_test
  import dwac_pkg::*;
;
  localparam logic [2:0] t_dir = `DWAC_TYPE_DIR;
  localparam logic [2:0] t_ind = `DWAC_TYPE_IND;
  logic clk = 1'b0, srst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0, rv = 1'b0;
  logic [11:0] pa = '0;
  logic [31:0] pwd = '0, prd, q;
  dwac_req_t rq = '0;
  logic prdy, perr, rr, done, pb, trap, mrd, mrdy, e;
  logic [23:0] ph, v;
  logic [2:0] cause, rwe, xv;
  logic [19:0] ma, a, p1, p2, p3;
  logic [15:0] md;
  logic [12:0] b;
  logic [3:0] rg;
  dwac_mode_t m;
  int err_count = 0;
  int total_checks = 0;
  int traps = 0;
  always #2 clk = ~clk;
  dwac_walk i_dwac_walk (.MCLK(clk), .SRST(srst), .PSEL(psel), .PENABLE(pen),
    .PWRITE(pwr), .PADDR(pa), .PWDATA(pwd), .PRDATA(prd), .PREADY(prdy),
    .PSLVERR(perr), .REQ_VALID(rv), .REQ(rq), .REQ_READY(rr), .DONE(done),
    .PHYS_ADDR(ph), .PHYS_BYTE(pb), .TRAP(trap), .TRAP_CAUSE(cause), .MEM_RD(mrd),
    .MEM_ADDR(ma), .MEM_RDATA(md), .MEM_READY(mrdy));
  dwac_mem_model i_dwac_mem_model (.MCLK(clk), .SRST(srst), .MEM_RD(mrd),
    .MEM_ADDR(ma), .MEM_RDATA(md), .MEM_READY(mrdy));
  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : complete_run
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    total_checks++;
    if (g !== x) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", n, x, g);
    end
  endtask : chk
  task automatic guard(input logic ok);
    if (!ok) begin
      chk("wait", 32'h1, 32'h0);
      complete_run();
    end
  endtask : guard
  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    pa <= ad;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (prdy !== 1'b1 && n < 20);
    guard(prdy === 1'b1);
    q = prd;
    e = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb
  function automatic dwac_desc_t mk(input logic [2:0] t, input logic [15:0] bs,
      input logic ac = 1'b1, input logic [2:0] p = 3'h7, input logic [3:0] wb = 4'h0,
      input logic [3:0] xb = 4'h3, input logic [1:0] dt = `DWAC_DT_PASS);
    return '{dt: dt, acc: ac, perm_r: p[2], perm_w: p[1], perm_e: p[0], typ: t,
      wb_top: wb, xb_top: xb, cb_top: 4'h3, base: bs};
  endfunction : mk
  task automatic put(input logic [19:0] ad, input dwac_desc_t d);
    i_dwac_mem_model.mem[int'(ad)] = {7'h0, d.perm_e, d.perm_w, d.perm_r, d.acc, d.dt, d.typ};
    i_dwac_mem_model.mem[int'(ad) + 1] = {4'h0, d.cb_top, d.xb_top, d.wb_top};
    i_dwac_mem_model.mem[int'(ad) + 2] = d.base;
    i_dwac_mem_model.mem[int'(ad) + 3] = 16'($urandom);
  endtask : put
  function automatic logic [23:0] dp(input logic [10:0] o);
    return {4'h0, b, 7'h0} + 24'(o);
  endfunction : dp
  // Brackets fixed at write 1, execute 2 for the random table
  function automatic logic perm(input dwac_mode_t md, input logic [3:0] r);
    logic [3:0] re;
    re = (md != DWAC_EXEC && r < 4'h1) ? 4'h1 : r;
    case (md)
      DWAC_WRITE: return rwe[1] && re <= 4'h1;
      DWAC_READ: return rwe[2] && re <= 4'h2;
      default: return rwe[0] && r >= 4'h1 && r <= 4'h2;
    endcase
  endfunction : perm
  task automatic go(input dwac_mode_t md, input logic ni, input logic [3:0] r,
      input logic [2:0] xc, input logic [23:0] xp);
    int n;
    logic bs;
    n = 0;
    bs = 1'($urandom);
    @(posedge clk);
    rv <= 1'b1;
    rq <= '{addr: v, byte_sel: bs, mode: md, new_instr: ni, cur_ring: r};
    do begin
      @(posedge clk);
      n++;
    end while (rr !== 1'b1 && n < 20);
    guard(rr === 1'b1);
    rv <= 1'b0;
    do begin
      @(posedge clk);
      n++;
    end while (done !== 1'b1 && n < 600);
    guard(done === 1'b1);
    if (xc != 3'h0) begin
      traps++;
    end
    chk("trap", 32'(xc != 3'h0), 32'(trap));
    chk("cause", 32'(xc), 32'(cause));
    if (xc == 3'h0) begin
      chk("phys", 32'(xp), 32'(ph));
      chk("byte", 32'(bs), 32'(pb));
    end
  endtask : go
  initial begin
    void'($urandom(32'h1da4f3db));
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    chk("ready", 32'h1, 32'(rr));
    apb(1'b0, `DWAC_ROOT_OFS, 32'h0);
    chk("root", 32'h0, q);
    apb(1'b0, 12'h010, 32'h0);
    chk("slverr", 32'h1, 32'(e));
    chk("rdata", 32'h0, q);
    apb(1'b1, `DWAC_CTRL_OFS, 32'h1);
    v = {1'b0, 23'($urandom)};
    go(DWAC_WRITE, 1'b1, 4'h0, 3'h0, v);
    $display("registers and bypass done");
    apb(1'b1, `DWAC_ROOT_OFS, {13'h0, t_dir, 16'h0100});
    repeat (6) begin
      a = 20'($urandom);
      b = 13'($urandom);
      v = {4'h8, a};
      put(20'h01000 + 20'(a[19:11]) * 4, mk(t_dir, {3'h0, b}));
      go(dwac_mode_t'($urandom_range(0, 2)), 1'b1, 4'h0, 3'h0, dp(a[10:0]));
    end
    put(20'h01000 + 20'(a[19:11]) * 4, mk(t_ind, 16'h0200));
    p2 = 20'h02000 + 20'({a[10:7], 2'b00}) * 4;
    put(p2, mk(t_dir, {3'h0, b}));
    go(DWAC_READ, 1'b1, 4'h0, 3'h0, dp(11'(a[6:0])));
    put(p2, mk(t_ind, 16'h0));
    go(DWAC_READ, 1'b1, 4'h0, `DWAC_CAUSE_STRUCT, 24'h0);
    $display("direct root done");
    apb(1'b1, `DWAC_ROOT_OFS, {13'h0, t_ind, 16'h0300});
    p1 = 20'h03000 + 20'(a[19:16]) * 4;
    p2 = 20'h04000 + 20'(a[15:11]) * 4;
    p3 = 20'h05000 + 20'(a[10:7]) * 4;
    put(p1, mk(t_dir, 16'h0));
    go(DWAC_READ, 1'b1, 4'h0, `DWAC_CAUSE_STRUCT, 24'h0);
    put(p1, mk(t_ind, 16'h0400));
    put(p2, mk(t_dir, {3'h0, b}));
    go(DWAC_READ, 1'b1, 4'h0, 3'h0, dp(a[10:0]));
    put(p2, mk(t_ind, 16'h0500));
    put(p3, mk(t_dir, {3'h0, b}));
    go(DWAC_WRITE, 1'b1, 4'h0, 3'h0, dp(11'(a[6:0])));
    put(p3, mk(t_ind, 16'h0));
    go(DWAC_READ, 1'b1, 4'h0, `DWAC_CAUSE_STRUCT, 24'h0);
    for (int i = 0; i < 4; i++) begin
      put(p2, mk(t_dir, {3'h0, b}, 1'b1, 3'h7, 4'h0, 4'h3, 2'(i)));
      go(DWAC_READ, 1'b1, 4'h0, (i == 2) ? 3'h0 : `DWAC_CAUSE_DT, dp(a[10:0]));
    end
    $display("indirect root done");
    put(p1, mk(t_ind, 16'h0400, 1'b0));
    put(p2, mk(t_dir, {3'h0, b}, 1'b0));
    go(DWAC_READ, 1'b1, 4'h0, `DWAC_CAUSE_NOACC, 24'h0);
    put(p1, mk(t_ind, 16'h0400, 1'b1, 3'h7, 4'h3, 4'h3));
    put(p2, mk(t_dir, {3'h0, b}, 1'b1, 3'h0));
    go(DWAC_WRITE, 1'b1, 4'h0, 3'h0, dp(a[10:0]));
    put(p1, mk(t_ind, 16'h0400, 1'b0));
    repeat (14) begin
      m = dwac_mode_t'($urandom_range(0, 2));
      rg = 4'($urandom_range(0, 3));
      rwe = 3'($urandom);
      put(p2, mk(t_dir, {3'h0, b}, 1'b1, rwe, 4'h1, 4'h2));
      xv = perm(m, rg) ? 3'h0 : `DWAC_CAUSE_VIOL;
      go(m, 1'b1, rg, xv, dp(a[10:0]));
    end
    $display("access control done");
    put(p2, mk(t_dir, {3'h0, b}, 1'b1, 3'h7, 4'h3, 4'h3));
    go(DWAC_READ, 1'b1, 4'h0, 3'h0, dp(a[10:0]));
    put(p2, mk(t_dir, {3'h0, b}, 1'b1, 3'h7, 4'h0, 4'h2));
    go(DWAC_READ, 1'b0, 4'h0, `DWAC_CAUSE_VIOL, 24'h0);
    go(DWAC_READ, 1'b1, 4'h0, 3'h0, dp(a[10:0]));
    apb(1'b0, `DWAC_ADDR_OFS, 32'h0);
    chk("addr reg", {8'h00, dp(a[10:0])}, q);
    apb(1'b0, `DWAC_STAT_OFS, 32'h0);
    chk("stat reg", {16'(traps), 16'h0000}, q);
    $display("effective ring done");
    complete_run();
  end
endmodule : dwac_walk_test
